// *** pkg/swic_pkg.sv ***
// Package of addresses, field layouts, reset values and codes for the wake-up control block
package swic_pkg;

   // ************************************************************
   // Sources and sensitivity
   // ************************************************************
   localparam int NUM_LINES   = 11;
   localparam int NUM_SRC     = 15;
   localparam int SRC_RTC     = 11;
   localparam int SRC_TB2     = 12;
   localparam int SRC_TB3     = 13;
   localparam int SRC_KEY     = 14;

   typedef enum logic [1:0]
   {
      SWIC_SENSE_LOW  = 2'h0,
      SWIC_SENSE_HIGH = 2'h1,
      SWIC_SENSE_FALL = 2'h2,
      SWIC_SENSE_RISE = 2'h3
   } swic_sense_t;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [31:0] ADDR_CFG0   = 32'hffffee10;
   localparam logic [31:0] ADDR_CFG1   = 32'hffffee14;
   localparam logic [31:0] ADDR_CFG2   = 32'hffffee18;
   localparam logic [31:0] ADDR_CFG3   = 32'hffffee1c;
   localparam logic [31:0] ADDR_CLEAR  = 32'hffffee20;
   localparam logic [31:0] ADDR_STATUS = 32'hffffee24;
   localparam logic [31:0] ADDR_MASK   = 32'hffffee28;
   localparam logic [31:0] ADDR_AUXEN  = 32'hffffee2c;
   localparam logic [31:0] ADDR_PEND   = 32'hffffee30;

   // Byte slot of each line within the four config words
   localparam int LINE_SLOT [NUM_LINES] = '{0, 1, 2, 3, 4, 10, 11, 12, 13, 14, 15};
   localparam int KEY_SLOT    = 5;
   localparam int FLD_EN      = 0;
   localparam int FLD_SENSE   = 4;
   localparam int AUX_RTC_EN  = 0;
   localparam int AUX_TB2_EN  = 1;
   localparam int AUX_TB3_EN  = 2;

   localparam logic [31:0] CFG_RST [4] = '{32'h20202020, 32'h30301020, 32'h20203030, 32'h20202020};
   localparam logic [31:0] CFG_WMASK [4] = '{32'h31313131, 32'h00003131, 32'h31310000, 32'h31313131};

   // ************************************************************
   // Clear codes and bus answers
   // ************************************************************
   localparam logic [3:0] CLR_KEY     = 4'h5;
   localparam logic [3:0] CLR_LINE5   = 4'ha;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : swic_pkg

// *** rtl/swic_ctrl.sv ***
// Standby wake-up interrupt control with AXI4-Lite registers
`timescale 1ns/1ns
module swic_ctrl
#(
   parameter int NUM_LINES = 11
)
(
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  s_awvalid_in,
   output logic                       s_awready_out,
   input  wire logic [31:0]           s_awaddr_in,
   input  wire logic                  s_wvalid_in,
   output logic                       s_wready_out,
   input  wire logic [31:0]           s_wdata_in,
   input  wire logic [3:0]            s_wstrb_in,
   output logic                       s_bvalid_out,
   input  wire logic                  s_bready_in,
   output logic [1:0]                 s_bresp_out,
   input  wire logic                  s_arvalid_in,
   output logic                       s_arready_out,
   input  wire logic [31:0]           s_araddr_in,
   output logic                       s_rvalid_out,
   input  wire logic                  s_rready_in,
   output logic [31:0]                s_rdata_out,
   output logic [1:0]                 s_rresp_out,
   input  wire logic [NUM_LINES-1:0]  ext_irq_in,
   input  wire logic                  key_wakeup_in,
   input  wire logic                  rtc_irq_in,
   input  wire logic                  timer_b2_irq_in,
   input  wire logic                  timer_b3_irq_in,
   output logic [NUM_LINES-1:0]       line_irq_out,
   output logic                       key_irq_out,
   output logic [14:0]                wake_req_out,
   output logic                       wake_out,
   output logic                       irq_out
);
   // ************************************************************
   // Elaboration check
   // ************************************************************
   // Clear codes are fixed to eleven lines
   if (NUM_LINES != swic_pkg::NUM_LINES)
   begin : g_bad_lines
      $error("swic_ctrl supports exactly eleven lines");
   end

   // ************************************************************
   // Bus slave state
   // ************************************************************
   logic        aw_hold_ff;
   logic [31:0] awaddr_ff;
   logic        w_hold_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;

   logic [31:0] cfg_ff [4];
   logic [14:0] status_ff;
   logic [14:0] mask_ff;
   logic [2:0]  auxen_ff;
   logic [14:0] wake_req_ff;
   logic        wake_ff;
   logic [NUM_LINES-1:0] line_irq_ff;
   logic        key_irq_ff;

   logic        do_wr;
   logic        do_rd;
   logic [31:0] wmask;
   logic [127:0] cfg_flat;
   logic [3:0]  wsel_cfg;
   logic        wsel_clr;
   logic        wsel_stat;
   logic        wsel_mask;
   logic        wsel_aux;
   logic        wr_hit;
   logic        rd_hit;
   logic [31:0] rd_mux;
   logic [3:0]  clr_code;
   logic [14:0] clr_vec;
   logic [14:0] en_vec;
   logic [14:0] hit_vec;
   logic [14:0] pend_vec;
   logic [14:0] nxt_status;
   logic [14:0] nxt_wake_req;

   // ************************************************************
   // Address decode
   // ************************************************************
   assign do_wr     = aw_hold_ff & w_hold_ff & ~bvalid_ff;
   assign do_rd     = s_arvalid_in & ~rvalid_ff;
   assign wmask     = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   assign wsel_cfg[0] = awaddr_ff == swic_pkg::ADDR_CFG0;
   assign wsel_cfg[1] = awaddr_ff == swic_pkg::ADDR_CFG1;
   assign wsel_cfg[2] = awaddr_ff == swic_pkg::ADDR_CFG2;
   assign wsel_cfg[3] = awaddr_ff == swic_pkg::ADDR_CFG3;
   assign wsel_clr  = awaddr_ff == swic_pkg::ADDR_CLEAR;
   assign wsel_stat = awaddr_ff == swic_pkg::ADDR_STATUS;
   assign wsel_mask = awaddr_ff == swic_pkg::ADDR_MASK;
   assign wsel_aux  = awaddr_ff == swic_pkg::ADDR_AUXEN;
   assign wr_hit    = (|wsel_cfg) | wsel_clr | wsel_stat | wsel_mask | wsel_aux;
   assign rd_hit    = (s_araddr_in == swic_pkg::ADDR_CFG0) | (s_araddr_in == swic_pkg::ADDR_CFG1) |
                      (s_araddr_in == swic_pkg::ADDR_CFG2) | (s_araddr_in == swic_pkg::ADDR_CFG3) |
                      (s_araddr_in == swic_pkg::ADDR_CLEAR) | (s_araddr_in == swic_pkg::ADDR_STATUS) |
                      (s_araddr_in == swic_pkg::ADDR_MASK) | (s_araddr_in == swic_pkg::ADDR_AUXEN) |
                      (s_araddr_in == swic_pkg::ADDR_PEND);
   // Clear register is write-only and reads as zero
   assign rd_mux    = (s_araddr_in == swic_pkg::ADDR_CFG0)   ? cfg_ff[0] :
                      (s_araddr_in == swic_pkg::ADDR_CFG1)   ? cfg_ff[1] :
                      (s_araddr_in == swic_pkg::ADDR_CFG2)   ? cfg_ff[2] :
                      (s_araddr_in == swic_pkg::ADDR_CFG3)   ? cfg_ff[3] :
                      (s_araddr_in == swic_pkg::ADDR_STATUS) ? {17'h0, status_ff} :
                      (s_araddr_in == swic_pkg::ADDR_MASK)   ? {17'h0, mask_ff} :
                      (s_araddr_in == swic_pkg::ADDR_AUXEN)  ? {29'h0, auxen_ff} :
                      (s_araddr_in == swic_pkg::ADDR_PEND)   ? {17'h0, pend_vec} :
                                                               32'h00000000;

   assign s_awready_out = ~aw_hold_ff & ~bvalid_ff;
   assign s_wready_out  = ~w_hold_ff & ~bvalid_ff;
   assign s_bvalid_out  = bvalid_ff;
   assign s_bresp_out   = bresp_ff;
   assign s_arready_out = ~rvalid_ff;
   assign s_rvalid_out  = rvalid_ff;
   assign s_rdata_out   = rdata_ff;
   assign s_rresp_out   = rresp_ff;

   // ************************************************************
   // Bus handshake
   // ************************************************************
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         aw_hold_ff <= 1'b0;
         awaddr_ff  <= 32'h00000000;
         w_hold_ff  <= 1'b0;
         wdata_ff   <= 32'h00000000;
         wstrb_ff   <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= swic_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_awvalid_in & s_awready_out)
         begin
            aw_hold_ff <= 1'b1;
            awaddr_ff  <= s_awaddr_in;
         end
         if (s_wvalid_in & s_wready_out)
         begin
            w_hold_ff <= 1'b1;
            wdata_ff  <= s_wdata_in;
            wstrb_ff  <= s_wstrb_in;
         end
         if (do_wr)
         begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= wr_hit ? swic_pkg::RESP_OKAY : swic_pkg::RESP_SLVERR;
         end
         else if (bvalid_ff & s_bready_in)
            bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= swic_pkg::RESP_OKAY;
      end
      else if (do_rd)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_mux;
         rresp_ff  <= rd_hit ? swic_pkg::RESP_OKAY : swic_pkg::RESP_SLVERR;
      end
      else if (s_rready_in)
         rvalid_ff <= 1'b0;
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   // Unused bytes hold their reset image; only enable and sense bits take writes
   for (genvar r = 0; r < 4; r++)
   begin : g_cfg
      always_ff @(posedge clk_in)
      begin
         if (rst_in)
            cfg_ff[r] <= swic_pkg::CFG_RST[r];
         else if (do_wr & wsel_cfg[r])
            cfg_ff[r] <= (cfg_ff[r] & ~(wmask & swic_pkg::CFG_WMASK[r])) |
                         (wdata_ff & wmask & swic_pkg::CFG_WMASK[r]);
      end
   end
   assign cfg_flat = {cfg_ff[3], cfg_ff[2], cfg_ff[1], cfg_ff[0]};

   // ************************************************************
   // Clear code decode
   // ************************************************************
   assign clr_code = wdata_ff[3:0];
   for (genvar s = 0; s < 15; s++)
   begin : g_clr
      if (s < 5)
      begin : g_lo
         assign clr_vec[s] = do_wr & wsel_clr & wstrb_ff[0] & (clr_code == 4'(s));
      end
      else if (s < swic_pkg::NUM_LINES)
      begin : g_hi
         assign clr_vec[s] = do_wr & wsel_clr & wstrb_ff[0] &
                             (clr_code == 4'(swic_pkg::CLR_LINE5 + 4'(s - 5)));
      end
      else if (s == swic_pkg::SRC_KEY)
      begin : g_key
         assign clr_vec[s] = do_wr & wsel_clr & wstrb_ff[0] & (clr_code == swic_pkg::CLR_KEY);
      end
      else
      begin : g_none
         assign clr_vec[s] = 1'b0;
      end
   end

   // ************************************************************
   // Source detection
   // ************************************************************
   for (genvar i = 0; i < NUM_LINES; i++)
   begin : g_line
      localparam int SB = swic_pkg::LINE_SLOT[i] * 8;
      assign en_vec[i] = cfg_flat[SB + swic_pkg::FLD_EN];
      swic_detect u_det
      (
         .clk_in   (clk_in),
         .rst_in   (rst_in),
         .sig_in   (ext_irq_in[i]),
         .sense_in (cfg_flat[SB + swic_pkg::FLD_SENSE +: 2]),
         .clr_in   (clr_vec[i]),
         .hit_out  (hit_vec[i]),
         .pend_out (pend_vec[i])
      );
   end

   // Key input arrives already qualified by the key logic, so it is taken high level
   swic_detect u_key_det
   (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .sig_in   (key_wakeup_in),
      .sense_in (swic_pkg::SWIC_SENSE_HIGH),
      .clr_in   (clr_vec[swic_pkg::SRC_KEY]),
      .hit_out  (hit_vec[swic_pkg::SRC_KEY]),
      .pend_out (pend_vec[swic_pkg::SRC_KEY])
   );
   assign en_vec[swic_pkg::SRC_KEY] = cfg_flat[swic_pkg::KEY_SLOT * 8 + swic_pkg::FLD_EN];

   // Rtc and timer requests are held and cleared in their own blocks
   assign hit_vec[swic_pkg::SRC_RTC]  = rtc_irq_in;
   assign hit_vec[swic_pkg::SRC_TB2]  = timer_b2_irq_in;
   assign hit_vec[swic_pkg::SRC_TB3]  = timer_b3_irq_in;
   assign pend_vec[swic_pkg::SRC_RTC] = rtc_irq_in;
   assign pend_vec[swic_pkg::SRC_TB2] = timer_b2_irq_in;
   assign pend_vec[swic_pkg::SRC_TB3] = timer_b3_irq_in;
   assign en_vec[swic_pkg::SRC_RTC]   = auxen_ff[swic_pkg::AUX_RTC_EN];
   assign en_vec[swic_pkg::SRC_TB2]   = auxen_ff[swic_pkg::AUX_TB2_EN];
   assign en_vec[swic_pkg::SRC_TB3]   = auxen_ff[swic_pkg::AUX_TB3_EN];

   // ************************************************************
   // Wake-up, pass-through and interrupt status
   // ************************************************************
   assign nxt_wake_req = pend_vec & en_vec;
   // Event set wins over a write-one clear in the same cycle
   assign nxt_status   = (status_ff & ~((do_wr & wsel_stat) ? {wdata_ff[14:8] & {7{wstrb_ff[1]}},
                                         wdata_ff[7:0] & {8{wstrb_ff[0]}}} : 15'h0000)) |
                         (hit_vec & en_vec);

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wake_req_ff <= 15'h0000;
         wake_ff     <= 1'b0;
         line_irq_ff <= '0;
         key_irq_ff  <= 1'b0;
         status_ff   <= 15'h0000;
      end
      else
      begin
         wake_req_ff <= nxt_wake_req;
         wake_ff     <= |nxt_wake_req;
         line_irq_ff <= ext_irq_in;
         key_irq_ff  <= key_wakeup_in;
         status_ff   <= nxt_status;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         mask_ff  <= 15'h0000;
         auxen_ff <= 3'h0;
      end
      else if (do_wr)
      begin
         if (wsel_mask & wstrb_ff[0])
            mask_ff[7:0] <= wdata_ff[7:0];
         if (wsel_mask & wstrb_ff[1])
            mask_ff[14:8] <= wdata_ff[14:8];
         if (wsel_aux & wstrb_ff[0])
            auxen_ff <= wdata_ff[2:0];
      end
   end

   assign wake_req_out = wake_req_ff;
   assign wake_out     = wake_ff;
   assign line_irq_out = line_irq_ff;
   assign key_irq_out  = key_irq_ff;
   assign irq_out      = |(status_ff & mask_ff);

   // ************************************************************
   // Checks
   // ************************************************************
   sequence sq_key_req;
      key_wakeup_in && en_vec[14] && !clr_vec[14];
   endsequence
   sequence sq_key_wake;
      pend_vec[14] ##1 wake_req_ff[14] && wake_ff;
   endsequence

   line_disabled_a : assert property (@(posedge clk_in) disable iff (rst_in)
      !en_vec[0] |=> !wake_req_ff[0])
      else $error("disabled line requests wake");
   key_gate_a : assert property (@(posedge clk_in) disable iff (rst_in)
      sq_key_req |=> sq_key_wake)
      else $error("key request did not wake");
   wake_any_a : assert property (@(posedge clk_in) disable iff (rst_in)
      wake_ff == (|wake_req_ff))
      else $error("wake differs from source requests");
   wake_hold_a : assert property (@(posedge clk_in) disable iff (rst_in)
      (pend_vec[11] && en_vec[11])[*2] |=> wake_req_ff[11])
      else $error("rtc request not held high");
   line_pass_a : assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 line_irq_out == $past(ext_irq_in))
      else $error("ordinary line interrupt not passed");
   key_pass_a : assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 key_irq_out == $past(key_wakeup_in))
      else $error("ordinary key interrupt not passed");
   key_clear_a : assert property (@(posedge clk_in) disable iff (rst_in)
      clr_vec[14] && !key_wakeup_in |=> !pend_vec[14] ##1 !wake_req_ff[14])
      else $error("key clear code did not clear");
   clear_code_a : assert property (@(posedge clk_in) disable iff (rst_in)
      do_wr && wsel_clr && wstrb_ff[0] && clr_code == 4'hf |-> clr_vec[10] && !clr_vec[4])
      else $error("code 1111 did not select line 10");
   sense_field_a : assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_flat[124 +: 2] == 2'h2 && $past(ext_irq_in[10]) && !ext_irq_in[10] |=> pend_vec[10])
      else $error("line 10 falling edge missed");

endmodule : swic_ctrl

// *** rtl/swic_detect.sv ***
// Per-source sensitivity detector with a latched pending request
`timescale 1ns/1ns
module swic_detect
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        sig_in,
   input  wire logic [1:0]  sense_in,
   input  wire logic        clr_in,
   output logic             hit_out,
   output logic             pend_out
);
   logic prev_ff;
   logic pend_ff;
   logic nxt_pend;

   // ************************************************************
   // Sensitivity decode
   // ************************************************************
   assign hit_out  = (sense_in == swic_pkg::SWIC_SENSE_LOW)  ? ~sig_in :
                     (sense_in == swic_pkg::SWIC_SENSE_HIGH) ? sig_in :
                     (sense_in == swic_pkg::SWIC_SENSE_FALL) ? (prev_ff & ~sig_in) :
                                                               (~prev_ff & sig_in);
   // Set wins over clear so a request at the clear is kept
   assign nxt_pend = hit_out | (pend_ff & ~clr_in);
   assign pend_out = pend_ff;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         prev_ff <= 1'b0;
         pend_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= sig_in;
         pend_ff <= nxt_pend;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   sequence sq_fall;
      (sense_in == 2'h2) && !sig_in && $past(sig_in);
   endsequence

   low_level_a : assert property (@(posedge clk_in) disable iff (rst_in)
      (sense_in == 2'h0) && !sig_in |=> pend_ff)
      else $error("low level not latched");
   rise_edge_a : assert property (@(posedge clk_in) disable iff (rst_in)
      (sense_in == 2'h3) && sig_in && $past(sig_in) && clr_in |=> !pend_ff)
      else $error("rising edge seen on steady high");
   fall_edge_a : assert property (@(posedge clk_in) disable iff (rst_in)
      sq_fall |=> pend_ff)
      else $error("falling edge not latched");
   clear_pend_a : assert property (@(posedge clk_in) disable iff (rst_in)
      clr_in && !hit_out |=> !pend_ff)
      else $error("pending not cleared");

endmodule : swic_detect

// *** test/swic_src_model.sv ***
// Far-side model of the interrupt pins and key wake-up logic
`timescale 1ns/1ns
module swic_src_model
(
   input  wire logic         clk_in,
   input  wire logic [14:0]  lvl_in,
   output logic [10:0]       ext_irq_out,
   output logic              key_out,
   output logic [2:0]        aux_out
);
   // Pins change just after an edge, like synchronous sources
   always_ff @(posedge clk_in)
   begin
      ext_irq_out <= lvl_in[10:0];
      aux_out     <= lvl_in[13:11];
      key_out     <= lvl_in[14];
   end
endmodule : swic_src_model

// *** test/tb_standby_wakeup_irq_control.sv ***
// Testbench of the wake-up control block
`timescale 1ns/1ns
module tb_standby_wakeup_irq_control;
   logic clk, rst, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, key, key_irq, wake, irq;
   logic [31:0] awa, wd, ara, rdat, d;
   logic [1:0]  bresp, rresp;
   logic [14:0] lvl, wreq;
   logic [10:0] ext, lirq;
   logic [2:0]  aux;
   int          err_count, checks, cyc;
   logic        ina;
   logic [3:0]  ws;

   swic_src_model u_swic_src_model (.clk_in(clk), .lvl_in(lvl), .ext_irq_out(ext), .key_out(key), .aux_out(aux));
   swic_ctrl u_swic_ctrl (.clk_in(clk), .rst_in(rst), .s_awvalid_in(awv), .s_awready_out(awr), .s_awaddr_in(awa),
      .s_wvalid_in(wv), .s_wready_out(wr_rdy), .s_wdata_in(wd), .s_wstrb_in(ws), .s_bvalid_out(bv),
      .s_bready_in(br), .s_bresp_out(bresp), .s_arvalid_in(arv), .s_arready_out(arr), .s_araddr_in(ara),
      .s_rvalid_out(rv), .s_rready_in(rr), .s_rdata_out(rdat), .s_rresp_out(rresp), .ext_irq_in(ext),
      .key_wakeup_in(key), .rtc_irq_in(aux[0]), .timer_b2_irq_in(aux[1]), .timer_b3_irq_in(aux[2]),
      .line_irq_out(lirq), .key_irq_out(key_irq), .wake_req_out(wreq), .wake_out(wake), .irq_out(irq));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   // Readiness is sampled mid-cycle; inputs only move at rising edges
   task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
      logic ta, tw, da, dw;
      da = 0;
      dw = 0;
      awa <= a;
      wd  <= v;
      awv <= 1'b1;
      wv  <= 1'b1;
      while (!(da && dw))
      begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wr_rdy;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         da = da | ta;
         dw = dw | tw;
      end
      br <= 1'b1;
      do
      begin
         @(negedge clk);
         ta = bv;
         tw = (bresp === er);
         @(posedge clk);
      end while (!ta);
      br <= 1'b0;
      chk(32'(tw), 32'h1);
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] v, input logic [1:0] er);
      logic t;
      ara <= a;
      arv <= 1'b1;
      do
      begin
         @(negedge clk);
         t = arr;
         @(posedge clk);
      end while (!t);
      arv <= 1'b0;
      rr  <= 1'b1;
      do
      begin
         @(negedge clk);
         t = rv;
         v = rdat;
         chk(32'(t & (rresp !== er)), 32'h0);
         @(posedge clk);
      end while (!t);
      rr <= 1'b0;
   endtask : rd

   task automatic end_sim;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   // ************************************************************
   // Sequence
   // ************************************************************
   initial
   begin
      clk = 0;
      forever #50 clk = ~clk;
   end

   // Guard against a slave that never answers
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         end_sim;
      end
   end

   initial
   begin
      {awv, wv, br, arv, rr, awa, wd, ara, lvl} = '0;
      ws = 4'hf;
      rst = 1;
      wt(8);
      rst <= 0;
      for (int i = 0; i < 4; i++)
      begin
         rd(swic_pkg::ADDR_CFG0 + 32'(4 * i), d, swic_pkg::RESP_OKAY);
         chk(d, swic_pkg::CFG_RST[i]);
      end
      rd(swic_pkg::ADDR_CLEAR, d, swic_pkg::RESP_OKAY);
      chk(d, 32'h0);
      wr(32'hffffee40, 32'h1, swic_pkg::RESP_SLVERR);
      rd(32'hffffee40, d, swic_pkg::RESP_SLVERR);
      // Every sense code on line 7: order is sense, clear, enable
      for (int c = 0; c < 4; c++)
      begin
         ina = (c == 0 || c == 2);
         lvl[7] <= ina;
         wt(3);
         wr(swic_pkg::ADDR_CFG3, 32'h20202000 | 32'(c << 4), swic_pkg::RESP_OKAY);
         wr(swic_pkg::ADDR_CLEAR, 32'hc, swic_pkg::RESP_OKAY);
         wr(swic_pkg::ADDR_CFG3, 32'h20202001 | 32'(c << 4), swic_pkg::RESP_OKAY);
         wt(5);
         chk(32'(wreq[7]), 32'h0);
         lvl[7] <= !ina;
         wt(5);
         chk(32'(wreq[7]), 32'h1);
         chk(32'(lirq[7]), 32'(!ina));
         // Clear while active: a level re-sets at once, an edge stays cleared
         wr(swic_pkg::ADDR_CLEAR, 32'hc, swic_pkg::RESP_OKAY);
         wt(3);
         chk(32'(wreq[7]), 32'(c < 2));
         wr(swic_pkg::ADDR_CFG3, 32'h20202000 | 32'(c << 4), swic_pkg::RESP_OKAY);
         wt(3);
         chk(32'(wreq[7]), 32'h0);
      end
      // Falling edge on all lines, then clear codes one by one
      wr(swic_pkg::ADDR_CFG3, 32'h20202020, swic_pkg::RESP_OKAY);
      lvl[10:0] <= 11'h7ff;
      wt(3);
      lvl[10:0] <= 11'h0;
      wt(5);
      for (int i = 6; i < 10; i++)
         wr(swic_pkg::ADDR_CLEAR, 32'(i), swic_pkg::RESP_OKAY);
      rd(swic_pkg::ADDR_PEND, d, swic_pkg::RESP_OKAY);
      chk(d & 32'h7ff, 32'h7ff);
      for (int i = 0; i < 11; i++)
      begin
         wr(swic_pkg::ADDR_CLEAR, 32'(i < 5 ? i : i + 5), swic_pkg::RESP_OKAY);
         rd(swic_pkg::ADDR_PEND, d, swic_pkg::RESP_OKAY);
         chk(d & 32'h7ff, (32'h7ff >> (i + 1)) << (i + 1));
      end
      // Key group wake-up, its clear code and the interrupt
      wr(swic_pkg::ADDR_CLEAR, 32'h5, swic_pkg::RESP_OKAY);
      wr(swic_pkg::ADDR_CFG1, 32'h30301120, swic_pkg::RESP_OKAY);
      wr(swic_pkg::ADDR_MASK, 32'h0, swic_pkg::RESP_OKAY);
      lvl[14] <= 1'b1;
      wt(5);
      chk({wreq[14], key_irq, irq}, 3'h6);
      wr(swic_pkg::ADDR_MASK, 32'h4000, swic_pkg::RESP_OKAY);
      chk(32'(irq), 32'h1);
      lvl[14] <= 1'b0;
      wt(4);
      chk(32'(wreq[14]), 32'h1);
      wr(swic_pkg::ADDR_CLEAR, 32'h5, swic_pkg::RESP_OKAY);
      wt(3);
      chk(32'(wreq[14]), 32'h0);
      rd(swic_pkg::ADDR_STATUS, d, swic_pkg::RESP_OKAY);
      chk(d & 32'h4000, 32'h4000);
      // Only byte lane 1 may clear bit 14
      ws <= 4'h1;
      wr(swic_pkg::ADDR_STATUS, 32'h4000, swic_pkg::RESP_OKAY);
      chk(32'(irq), 32'h1);
      ws <= 4'hf;
      wr(swic_pkg::ADDR_STATUS, 32'h4000, swic_pkg::RESP_OKAY);
      chk(32'(irq), 32'h0);
      // Clock and timer sources
      wr(swic_pkg::ADDR_AUXEN, 32'h7, swic_pkg::RESP_OKAY);
      lvl[13:11] <= 3'h7;
      wt(5);
      chk({wreq[13:11], wake}, 4'hf);
      end_sim;
   end
endmodule : tb_standby_wakeup_irq_control
